//--- rtl/tenbase_t_codec_and_reset_control.sv
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`include "tenbase_cfg.svh"
module tenbase_t_codec_and_reset_control
   import tenbase_pkg::*;
#(
   parameter int LINK_PERIOD_CYC = `LINK_PERIOD_CYC,
   parameter int ED_IDLE_CYC = `ED_IDLE_CYC,
   parameter int WAKE_CYC = `ED_WAKE_CYC,
   parameter int TW = 21
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic reset_pin_n_i,
   input wire logic [1:0] strap_i,
   input wire logic tx_clk_i,
   input wire logic tx_en_i,
   input wire logic txd_i,
   input wire logic rx_pos_i,
   input wire logic rx_neg_i,
   output logic line_p_o,
   output logic line_n_o,
   output logic line_emph_o,
   output logic line_en_o,
   output logic crs_o,
   output logic rxd_o,
   output logic rx_clk_o,
   output logic low_power_o,
   output logic irq_o
);
   logic [7:0] sync1, sync2;
   logic [1:0] strap_s, strap_q;
   logic rstn_s, neg_s, pos_s, txd_s, txen_s, txclk_s;
   logic txclk_d, pos_d, neg_d;
   logic hw_rst, core_rst, srst_busy;
   logic [5:0] srst_cnt;
   logic [5:0] idx;
   logic wr, rd;
   logic bctl_pd, ed_en, pol_bad;
   logic [2:0] irq_stat, irq_mask, irq_ev, irq_clr;
   logic [31:0] rdata;
   logic trans, burst_end, inv_pulse;
   logic [2:0] quiet;
   logic [1:0] burst, inv_cnt;
   logic first_neg;
   logic [4:0] tail;
   logic [1:0] rxph;
   pwr_t pwr;
   logic [TW-1:0] tmr, pcnt;
   logic pulse_req, tx_stb;

   // every strap, reset pin, line and link pin passes two flops before anything looks at it
   always_ff @(posedge clk_i) begin
      sync1 <= {strap_i, reset_pin_n_i, rx_neg_i, rx_pos_i, txd_i, tx_en_i, tx_clk_i};
      sync2 <= sync1;
   end
   assign {strap_s, rstn_s, neg_s, pos_s, txd_s, txen_s, txclk_s} = sync2;

   // previous samples for edge finding
   always_ff @(posedge clk_i) begin
      txclk_d <= txclk_s;
      pos_d <= pos_s;
      neg_d <= neg_s;
   end

   // reset sources: power-on input, pin, and the software reset window
   assign hw_rst = ~rstn_s;
   assign core_rst = rst_i | hw_rst | srst_busy;
   assign tx_stb = txclk_s & ~txclk_d;
   assign idx = adr_i[7:2];
   assign wr = cyc_i & stb_i & we_i & ~ack_o;
   assign rd = cyc_i & stb_i & ~we_i & ~ack_o;

   // straps captured only by power-on or pin reset, never by software reset
   always_ff @(posedge clk_i) begin
      if (rst_i | hw_rst) begin
         strap_q <= strap_s;
      end
   end

   // software reset timer; busy bit reads back until done
   always_ff @(posedge clk_i) begin
      if (rst_i | hw_rst) begin
         srst_busy <= 1'b0;
         srst_cnt <= 6'h00;
      end else if (srst_busy) begin
         srst_cnt <= srst_cnt + 6'h01;
         if (srst_cnt == 6'(`SRST_CYC - 1)) begin
            srst_busy <= 1'b0;
         end
      end else if (wr && idx == `BCTL_IDX && sel_i[1] && dat_i[`BCTL_RESET_BIT]) begin
         srst_busy <= 1'b1;
         srst_cnt <= 6'h00;
      end
   end

   // writable control; power-down and energy-detect defaults follow the latched straps, the interrupt mask resets to IMASK_RST
   always_ff @(posedge clk_i) begin
      if (core_rst) begin
         bctl_pd <= strap_q[1];
         ed_en <= strap_q[0];
         irq_mask <= `IMASK_RST;
      end else if (wr) begin
         if (idx == `BCTL_IDX && sel_i[1]) begin
            bctl_pd <= dat_i[`BCTL_PD_BIT];
         end else if (idx == `ENERGY_DETECT_CONTROL_REG_IDX && sel_i[1]) begin
            ed_en <= dat_i[`ENERGY_DETECT_CONTROL_REG_EN_BIT];
         end else if (idx == `IMASK_IDX && sel_i[0]) begin
            irq_mask <= dat_i[2:0];
         end
      end
   end

   // sticky events; a new event beats a same-cycle write-one clear
   assign irq_clr = (wr && idx == `ISTAT_IDX && sel_i[0]) ? dat_i[2:0] : 3'h0;
   always_comb begin
      irq_ev = 3'h0;
      irq_ev[`IRQ_POL] = inv_pulse && inv_cnt == 2'(`POL_INV_COUNT - 1);
      irq_ev[`IRQ_WAKE] = (pwr == P_LOW) && trans && ed_en && !bctl_pd;
      irq_ev[`IRQ_RXEND] = burst_end && burst == 2'h2;
   end
   always_ff @(posedge clk_i) begin
      if (core_rst) begin
         irq_stat <= `ISTAT_RST;
         irq_o <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // read mux; unmapped words read zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (idx == `BCTL_IDX) begin
         rdata[`BCTL_RESET_BIT] = srst_busy;
         rdata[`BCTL_PD_BIT] = bctl_pd;
      end else if (idx == `TENM_IDX) begin
         rdata[`TENM_POLBAD_BIT] = pol_bad;
      end else if (idx == `ENERGY_DETECT_CONTROL_REG_IDX) begin
         rdata[`ENERGY_DETECT_CONTROL_REG_EN_BIT] = ed_en;
         rdata[`ENERGY_DETECT_CONTROL_REG_LP_BIT] = (pwr == P_LOW);
      end else if (idx == `ISTAT_IDX) begin
         rdata[2:0] = irq_stat;
      end else if (idx == `IMASK_IDX) begin
         rdata[2:0] = irq_mask;
      end
   end

   // one-wait-state slave; answers even while software reset runs
   always_ff @(posedge clk_i) begin
      if (rst_i | hw_rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         dat_o <= rd ? rdata : 32'h0000_0000;
      end
   end

   // burst tracking: a lone pulse is a link pulse, two or more a frame
   assign trans = (pos_s & ~pos_d) | (neg_s & ~neg_d);
   assign burst_end = !trans && quiet == 3'(`CRS_OFF_CYC - 1);
   assign inv_pulse = burst_end && burst == 2'h1 && first_neg;
   always_ff @(posedge clk_i) begin
      if (core_rst) begin
         quiet <= 3'(`CRS_OFF_CYC);
         burst <= 2'h0;
         first_neg <= 1'b0;
         inv_cnt <= 2'h0;
         pol_bad <= 1'b0;
      end else if (trans) begin
         quiet <= 3'h0;
         if (burst == 2'h0) begin
            first_neg <= neg_s & ~neg_d;
         end
         if (burst != 2'h2) begin
            burst <= burst + 2'h1;
         end
      end else begin
         if (quiet != 3'(`CRS_OFF_CYC)) begin
            quiet <= quiet + 3'h1;
         end
         if (burst_end) begin
            burst <= 2'h0;
            if (burst == 2'h1) begin
               // a normal pulse in between breaks the run
               inv_cnt <= first_neg ? ((inv_cnt == 2'h3) ? inv_cnt : inv_cnt + 2'h1) : 2'h0;
               if (inv_pulse && inv_cnt == 2'(`POL_INV_COUNT - 1)) begin
                  pol_bad <= 1'b1;
               end
            end
         end
      end
   end

   // carrier, corrected data and the trailing receive clock
   always_ff @(posedge clk_i) begin
      if (core_rst) begin
         crs_o <= 1'b0;
         rxd_o <= 1'b0;
         tail <= 5'h00;
         rxph <= 2'h0;
         rx_clk_o <= 1'b0;
      end else begin
         crs_o <= (pwr == P_ON) && burst == 2'h2 && quiet < 3'(`CRS_OFF_CYC - 1);
         rxd_o <= pol_bad ? neg_s : pos_s;
         if (crs_o) begin
            tail <= 5'(`RXCLK_TAIL_CYC);
         end else if (tail != 5'h00) begin
            tail <= tail - 5'h01;
         end
         if (crs_o || tail != 5'h00) begin
            rxph <= (rxph == 2'(`HALF_CYC - 1)) ? 2'h0 : rxph + 2'h1;
            if (rxph == 2'(`HALF_CYC - 1)) begin
               rx_clk_o <= ~rx_clk_o;
            end
         end else begin
            rxph <= 2'h0;
            rx_clk_o <= 1'b0;
         end
      end
   end

   // pulse period timer restarts whenever data is being sent
   always_ff @(posedge clk_i) begin
      if (core_rst || txen_s || tmr == TW'(LINK_PERIOD_CYC - 1)) begin
         tmr <= '0;
      end else begin
         tmr <= tmr + 1'b1;
      end
   end
   // link pulse when idle, energy-detect pulse in low power
   assign pulse_req = tmr == TW'(LINK_PERIOD_CYC - 1) && !txen_s && (pwr == P_ON || pwr == P_LOW);

   // power state; pcnt times idle in P_ON and the wake sequence
   always_ff @(posedge clk_i) begin
      if (core_rst) begin
         pwr <= P_ON;
         pcnt <= '0;
         low_power_o <= 1'b0;
      end else begin
         low_power_o <= (pwr != P_ON);
         pcnt <= (&pcnt) ? pcnt : pcnt + 1'b1;
         case (pwr)
            P_ON: begin
               if (bctl_pd) begin
                  pwr <= P_DOWN;
               end else if (trans || txen_s) begin
                  pcnt <= '0;
               end else if (ed_en && pcnt == TW'(ED_IDLE_CYC - 1)) begin
                  pwr <= P_LOW;
               end
            end
            P_DOWN: begin
               pcnt <= '0;
               if (!bctl_pd) begin
                  pwr <= P_WAKE;
               end
            end
            P_LOW: begin
               pcnt <= '0;
               if (bctl_pd) begin
                  pwr <= P_DOWN;
               end else if (trans || !ed_en) begin
                  pwr <= P_WAKE;
               end
            end
            default: begin
               if (bctl_pd) begin
                  pwr <= P_DOWN;
               end else if (pcnt == TW'(WAKE_CYC - 1)) begin
                  pwr <= P_ON;
                  pcnt <= '0;
               end
            end
         endcase
      end
   end

   // transmit data only runs at full power; pulses also go out in low power
   manchester_tx u_enc (
      .clk_i(clk_i),
      .rst_i(core_rst),
      .stb_i(tx_stb),
      .en_i(txen_s && pwr == P_ON),
      .bit_i(txd_s),
      .pulse_i(pulse_req),
      .line_p_o(line_p_o),
      .line_n_o(line_n_o),
      .emph_o(line_emph_o),
      .line_en_o(line_en_o)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (core_rst);
   property p_pol_set;
      $rose(pol_bad) |-> $past(inv_cnt) == 2'h2 && $past(inv_pulse);
   endproperty
   a_pol_set: assert property (p_pol_set) else $error("bad polarity set early");
   property p_pol_held;
      pol_bad |=> pol_bad;
   endproperty
   a_pol_held: assert property (p_pol_held) else $error("polarity flag lost");
   property p_rxd_fix;
      pol_bad |=> rxd_o == $past(neg_s);
   endproperty
   a_rxd_fix: assert property (p_rxd_fix) else $error("received data not corrected");
   property p_crs_off;
      (!trans)[*8] |-> !crs_o;
   endproperty
   a_crs_off: assert property (p_crs_off) else $error("carrier held too long");
   property p_rxclk_tail;
      $fell(crs_o) |-> (tail != 5'h00)[*8];
   endproperty
   a_rxclk_tail: assert property (p_rxclk_tail) else $error("receive clock stopped early");
   property p_pd;
      bctl_pd |=> pwr == P_DOWN;
   endproperty
   a_pd: assert property (p_pd) else $error("power-down not entered");
   property p_wake;
      pwr == P_LOW && trans && !bctl_pd |=> pwr == P_WAKE;
   endproperty
   a_wake: assert property (p_wake) else $error("activity did not wake");
   property p_ed_pulse;
      pwr == P_LOW && tmr == TW'(LINK_PERIOD_CYC - 1) && !txen_s |-> ##2 line_en_o;
   endproperty
   a_ed_pulse: assert property (p_ed_pulse) else $error("energy pulse missed");
   property p_low_needs_en;
      !ed_en |=> pwr != P_LOW;
   endproperty
   a_low_needs_en: assert property (p_low_needs_en) else $error("low power without enable");
   property p_strap_cap;
      @(posedge clk_i) disable iff (rst_i) hw_rst |=> strap_q == $past(strap_s);
   endproperty
   a_strap_cap: assert property (p_strap_cap) else $error("straps not recaptured");
   property p_srst_len;
      @(posedge clk_i) disable iff (rst_i || hw_rst) $rose(srst_busy) |-> ##40 !srst_busy;
   endproperty
   a_srst_len: assert property (p_srst_len) else $error("software reset length wrong");
   property p_srst_strap;
      @(posedge clk_i) disable iff (rst_i || hw_rst) srst_busy |=> $stable(strap_q);
   endproperty
   a_srst_strap: assert property (p_srst_strap) else $error("straps changed by software reset");
   c_pol: cover property ($rose(pol_bad));
   c_wake: cover property (pwr == P_LOW ##1 pwr == P_WAKE);
   c_frame: cover property ($fell(crs_o));
endmodule // tenbase_t_codec_and_reset_control

//--- rtl/tenbase_cfg.svh
`ifndef TENBASE_CFG_SVH
`define TENBASE_CFG_SVH
// clock and bit timing
`define CLK_MHZ 40
`define BIT_NS 100
`define BIT_CYC ((`BIT_NS * `CLK_MHZ) / 1000)
`define HALF_CYC (`BIT_CYC / 2)
`define TX_CELL_NS 200
`define TX_HALF_CYC (((`TX_CELL_NS * `CLK_MHZ) / 1000) / 2)
`define CRS_OFF_NS 150
`define CRS_OFF_CYC ((`CRS_OFF_NS * `CLK_MHZ) / 1000)
`define RXCLK_TAIL_BITS 5
`define RXCLK_TAIL_CYC (`RXCLK_TAIL_BITS * `BIT_CYC)
`define LP_NS 100
`define LP_CYC ((`LP_NS * `CLK_MHZ + 999) / 1000)
`define LINK_PERIOD_MS 16
`define LINK_PERIOD_CYC (`LINK_PERIOD_MS * `CLK_MHZ * 1000)
`define ED_IDLE_MS 32
`define ED_IDLE_CYC (`ED_IDLE_MS * `CLK_MHZ * 1000)
`define ED_WAKE_US 10
`define ED_WAKE_CYC (`ED_WAKE_US * `CLK_MHZ)
`define SRST_NS 1000
`define SRST_CYC ((`SRST_NS * `CLK_MHZ) / 1000)
`define POL_INV_COUNT 3
// register indexes, byte address is index times four
`define BCTL_IDX 6'h00
`define TENM_IDX 6'h1a
`define ENERGY_DETECT_CONTROL_REG_IDX 6'h1d
`define ISTAT_IDX 6'h20
`define IMASK_IDX 6'h21
// field positions
`define BCTL_RESET_BIT 15
`define BCTL_PD_BIT 11
`define TENM_POLBAD_BIT 4
`define ENERGY_DETECT_CONTROL_REG_EN_BIT 15
`define ENERGY_DETECT_CONTROL_REG_LP_BIT 0
`define IRQ_POL 0
`define IRQ_WAKE 1
`define IRQ_RXEND 2
// reset values
`define IMASK_RST 3'h0
`define ISTAT_RST 3'h0
`endif

//--- rtl/tenbase_pkg.sv
package tenbase_pkg;
   typedef enum logic [1:0] {P_ON, P_DOWN, P_LOW, P_WAKE} pwr_t;
   typedef enum logic [1:0] {T_IDLE, T_DATA, T_TAIL, T_PULSE} tx_t;
endpackage

//--- rtl/manchester_tx.sv
`timescale 1ns/100ps
`include "tenbase_cfg.svh"
module manchester_tx
   import tenbase_pkg::*;
#(
   parameter int HALF_CYC = `TX_HALF_CYC,
   parameter int PULSE_CYC = `LP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stb_i,
   input wire logic en_i,
   input wire logic bit_i,
   input wire logic pulse_i,
   output logic line_p_o,
   output logic line_n_o,
   output logic emph_o,
   output logic line_en_o
);
   tx_t st;
   logic [3:0] cnt;
   logic bitq;
   logic lvl;
   logic drv;

   // cell sequencing; a new cell restarts on every rising link clock edge with enable high, except during the tail
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= T_IDLE;
         cnt <= 4'h0;
         bitq <= 1'b0;
      end else begin
         case (st)
            T_IDLE: begin
               cnt <= 4'h0;
               if (stb_i && en_i) begin
                  st <= T_DATA;
                  bitq <= bit_i;
               end else if (pulse_i) begin
                  st <= T_PULSE;
               end
            end
            T_DATA: begin
               if (stb_i) begin
                  cnt <= 4'h0;
                  if (en_i) begin
                     bitq <= bit_i;
                  end else begin
                     st <= T_TAIL;
                  end
               end else if (cnt != 4'hf) begin
                  cnt <= cnt + 4'h1;
               end
            end
            T_TAIL: begin
               cnt <= cnt + 4'h1;
               if (cnt == 4'(2 * HALF_CYC - 1)) begin
                  st <= T_IDLE;
               end
            end
            // a frame start cuts a link pulse short rather than losing its first bit
            default: begin
               cnt <= cnt + 4'h1;
               if (stb_i && en_i) begin
                  st <= T_DATA;
                  bitq <= bit_i;
                  cnt <= 4'h0;
               end else if (cnt == 4'(PULSE_CYC - 1)) begin
                  st <= T_IDLE;
               end
            end
         endcase
      end
   end

   // first half inverted, second half true: rising mid-cell for a one
   always_comb begin
      drv = (st != T_IDLE);
      lvl = drv;
      if (st == T_DATA) begin
         lvl = (cnt < 4'(HALF_CYC)) ? ~bitq : bitq;
      end
   end

   // registered pair; emphasis marks the cycle after each level change
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_p_o <= 1'b0;
         line_n_o <= 1'b0;
         emph_o <= 1'b0;
         line_en_o <= 1'b0;
      end else begin
         line_p_o <= lvl;
         line_n_o <= drv & ~lvl;
         emph_o <= drv && (lvl != line_p_o);
         line_en_o <= drv;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_first_half;
      (st != T_TAIL) && stb_i && en_i |-> ##2 line_en_o && (line_p_o == !$past(bit_i, 2));
   endproperty
   a_first_half: assert property (p_first_half) else $error("first half cell not inverted");
   property p_second_half;
      (st != T_TAIL) && stb_i && en_i |-> ##6 line_p_o == $past(bit_i, 6);
   endproperty
   a_second_half: assert property (p_second_half) else $error("second half cell wrong");
   property p_last_edge;
      $fell(line_en_o) |-> $past(line_p_o);
   endproperty
   a_last_edge: assert property (p_last_edge) else $error("line released while low");
   property p_tail_high;
      st == T_TAIL |=> line_p_o && line_en_o;
   endproperty
   a_tail_high: assert property (p_tail_high) else $error("tail not held high");
   property p_pulse_width;
      st == T_IDLE && pulse_i && !(stb_i && en_i) |-> ##2 line_p_o[*4] ##1 !line_en_o;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("link pulse width wrong");
   c_frame_end: cover property (st == T_TAIL ##1 st == T_IDLE);
endmodule // manchester_tx

//--- test/mac_tx_model.sv
`timescale 1ns/100ps
// controller side of the transmit link; its clock runs only inside frames
module mac_tx_model (
   output logic tx_clk_o,
   output logic tx_en_o,
   output logic txd_o
);
   initial begin
      tx_clk_o = 1'b0;
      tx_en_o = 1'b0;
      txd_o = 1'b0;
   end
   // data moves on the falling edge, so it is settled at the rising one
   task automatic send(input int len, input logic [63:0] d);
      #7.3;
      for (int i = 0; i < len; i++) begin
         tx_en_o = 1'b1;
         txd_o = d[i];
         #100 tx_clk_o = 1'b1;
         #100 tx_clk_o = 1'b0;
      end
      // closing edge with enable low; data is no longer held
      tx_en_o = 1'b0;
      txd_o = ~d[len-1];
      #100 tx_clk_o = 1'b1;
      #100 tx_clk_o = 1'b0;
   endtask
endmodule // mac_tx_model

//--- test/test_tenbase_t_codec_and_reset_control.sv
`timescale 1ns/100ps
module test_tenbase_t_codec_and_reset_control;
   logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, q, lfsr = 32'h822b;
   logic [3:0] sel_i = 4'hf;
   logic [1:0] strap_i = 2'h0;
   logic reset_pin_n_i = 1'b1, rx_pos_i = 1'b0, rx_neg_i = 1'b0, watch = 1'b0, last;
   logic tx_clk_i, tx_en_i, txd_i, ack_o, line_p_o, line_n_o, line_emph_o, line_en_o;
   logic crs_o, rxd_o, rx_clk_o, low_power_o, irq_o;
   int fails = 0, cmp_count = 0, n, k, lt;

   initial forever #12.5 clk_i = ~clk_i;

   tenbase_t_codec_and_reset_control #(.LINK_PERIOD_CYC(200), .ED_IDLE_CYC(300), .WAKE_CYC(20))
      tenbase_t_codec_and_reset_control_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .reset_pin_n_i(reset_pin_n_i), .strap_i(strap_i), .tx_clk_i(tx_clk_i), .tx_en_i(tx_en_i),
      .txd_i(txd_i), .rx_pos_i(rx_pos_i), .rx_neg_i(rx_neg_i), .line_p_o(line_p_o), .line_n_o(line_n_o),
      .line_emph_o(line_emph_o), .line_en_o(line_en_o), .crs_o(crs_o), .rxd_o(rxd_o),
      .rx_clk_o(rx_clk_o), .low_power_o(low_power_o), .irq_o(irq_o));
   mac_tx_model mac_tx_model_inst (.tx_clk_o(tx_clk_i), .tx_en_o(tx_en_i), .txd_o(txd_i));

   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a wait that runs out is a mismatch and ends the run
   task automatic wait_for(ref logic s, input logic v, input int lim);
      for (n = 0; n < lim && s !== v; n++) @(posedge clk_i);
      if (n == lim) begin
         fails++;
         final_report();
      end
   endtask

   // classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= v;
      wait_for(ack_o, 1'b1, 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // one comparator pulse of two cycles, then a quiet gap
   task automatic pulse(input logic neg, input int gap);
      @(posedge clk_i);
      rx_pos_i <= !neg;
      rx_neg_i <= neg;
      repeat (2) @(posedge clk_i);
      rx_pos_i <= 1'b0;
      rx_neg_i <= 1'b0;
      repeat (gap) @(posedge clk_i);
   endtask

   // first half of a cell carries the inverted bit, second half the bit
   task automatic tx_cell(input logic b);
      repeat (7) @(posedge clk_i);
      chk(32'(line_p_o), 32'(!b));
      chk(32'(line_en_o), 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(line_emph_o), 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(line_p_o), 32'(b));
      chk(32'(line_n_o), 32'(!b));
   endtask

   always @(posedge tx_clk_i) begin
      if (watch && tx_en_i) begin
         fork
            tx_cell(txd_i);
         join_none
      end
   end

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h68, 32'h0);
      rd(8'h74, 32'h0);
      rd(8'h80, 32'h0);
      wb(1'b1, 8'h04, 32'hffff);
      rd(8'h04, 32'h0);
      for (int i = 0; i < 4; i++) begin
         lfsr = step(lfsr);
         wb(1'b1, 8'h84, lfsr);
         rd(8'h84, {29'h0, lfsr[2:0]});
      end
      $display("registers done");
      wait_for(line_p_o, 1'b1, 260);
      wait_for(line_p_o, 1'b0, 20);
      chk(n, 4);
      wait_for(line_p_o, 1'b1, 260);
      chk(32'(n > 194 && n < 198), 32'h1);
      $display("link pulse done");
      lfsr = step(lfsr);
      watch = 1'b1;
      mac_tx_model_inst.send(8 + int'(lfsr[2:0]), {lfsr, step(lfsr)});
      last = 1'b0;
      for (k = 0; k < 40 && line_en_o === 1'b1; k++) begin
         last = line_p_o;
         @(posedge clk_i);
      end
      chk(32'({last, k < 40}), 32'h3);
      chk(32'(line_n_o), 32'h0);
      $display("transmit done");
      for (int i = 0; i < 12; i++) begin
         pulse(i[0], 0);
         if (i == 6) chk(32'(crs_o), 32'h1);
      end
      wait_for(crs_o, 1'b0, 12);
      chk(32'(n <= 8), 32'h1);
      last = rx_clk_o;
      lt = 0;
      for (k = 1; k <= 30; k++) begin
         @(posedge clk_i);
         if (rx_clk_o !== last) lt = k;
         last = rx_clk_o;
      end
      chk(32'(lt >= 17 && lt <= 23), 32'h1);
      rd(8'h80, 32'h4);
      wb(1'b1, 8'h80, 32'h4);
      rd(8'h80, 32'h0);
      $display("receive done");
      // a lone positive pulse between breaks the run of three
      pulse(1'b1, 20);
      pulse(1'b1, 20);
      pulse(1'b0, 20);
      pulse(1'b1, 20);
      pulse(1'b1, 20);
      rd(8'h68, 32'h0);
      pulse(1'b1, 20);
      rd(8'h68, 32'h10);
      rx_neg_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk(32'(rxd_o), 32'h1);
      rx_neg_i <= 1'b0;
      wb(1'b1, 8'h84, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h0);
      wb(1'b1, 8'h84, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h1);
      wb(1'b1, 8'h80, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h0);
      $display("polarity done");
      wb(1'b1, 8'h00, 32'h0800);
      wait_for(low_power_o, 1'b1, 10);
      wb(1'b1, 8'h00, 32'h0);
      wait_for(low_power_o, 1'b0, 40);
      wb(1'b1, 8'h74, 32'h8000);
      wait_for(low_power_o, 1'b1, 400);
      rd(8'h74, 32'h8001);
      wait_for(line_en_o, 1'b1, 260);
      pulse(1'b0, 0);
      wait_for(low_power_o, 1'b0, 60);
      wb(1'b1, 8'h74, 32'h0);
      rd(8'h80, 32'h2);
      $display("power done");
      wb(1'b1, 8'h84, 32'h7);
      strap_i <= 2'h1;
      wb(1'b1, 8'h00, 32'h8000);
      repeat (120) @(posedge clk_i);
      rd(8'h00, 32'h0);
      rd(8'h84, 32'h0);
      rd(8'h74, 32'h0);
      reset_pin_n_i <= 1'b0;
      repeat (50) @(posedge clk_i);
      reset_pin_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(8'h74, 32'h8000);
      rd(8'h68, 32'h0);
      $display("resets done");
      final_report();
   end
endmodule // test_tenbase_t_codec_and_reset_control
